// ==== rtl/ssw_rst_map.svh ====
`ifndef SSW_RST_MAP_SVH
`define SSW_RST_MAP_SVH
// Clock period in ps (200 MHz)
`define SSW_CLK_PS 64'h0000_0000_0000_1388
// Prescaler: 1 us tick from a 200 MHz clock
`define SSW_TICK_CYC 16'h00C8
// Release delay, typical, in ms
`define SSW_TD_MS 32'h0000_00B4
// Watchdog timeout, typical, in ms
`define SSW_TOUT_MS 32'h0000_0578
// Microseconds in one millisecond
`define SSW_US_PER_MS 32'h0000_03E8
`endif

// ==== rtl/ssw_pkg.sv ====
`default_nettype none
package ssw_pkg;
   typedef enum logic [1:0] {SSW_HOLD, SSW_DELAY, SSW_RUN} ssw_state_t;
   typedef struct packed {
      logic supply_good;
      logic manual_reset_n;
      logic watchdog_kick_in;
   } ssw_in_t;
endpackage
`default_nettype wire

// ==== rtl/ssw_tick.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "ssw_rst_map.svh"
// ****************************************
// Microsecond timebase divider
// ****************************************
module ssw_tick (
   input wire logic clk_sys,
   input wire logic rst_n,
   output logic tick_us
);
   logic [15:0] cnt_r;
   wire logic wrap = (cnt_r == (`SSW_TICK_CYC - 16'h0001));
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         cnt_r <= 16'h0000;
      end else begin
         cnt_r <= wrap ? 16'h0000 : cnt_r + 16'h0001;
      end
   end
   assign tick_us = wrap;
endmodule // ssw_tick
`default_nettype wire

// ==== rtl/ssw_supervisor.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "ssw_rst_map.svh"
module ssw_supervisor #(
   parameter logic [31:0] TD_US = `SSW_TD_MS * `SSW_US_PER_MS,
   parameter logic [31:0] TOUT_US = `SSW_TOUT_MS * `SSW_US_PER_MS,
   parameter bit HAS_WDOG = 1'b1
) (
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire ssw_pkg::ssw_in_t pins,
   output logic reset_n,
   output logic reset_hi
);
   // ****************************************
   // Timebase and input decode
   // ****************************************
   logic tick_us;
   ssw_tick ssw_tick_i (
      .clk_sys(clk_sys),
      .rst_n(rst_n),
      .tick_us(tick_us)
   );

   ssw_pkg::ssw_state_t state_r;
   ssw_pkg::ssw_state_t state_nxt;
   logic [31:0] dly_r;
   logic [31:0] wd_r;
   logic kick_r;
   logic rst_out_r;

   // ****************************************
   // State decode
   // ****************************************
   function automatic logic is_state(
      input ssw_pkg::ssw_state_t cur,
      input ssw_pkg::ssw_state_t want
   );
      return cur == want;
   endfunction

   wire logic in_hold = is_state(state_r, ssw_pkg::SSW_HOLD);
   wire logic in_delay = is_state(state_r, ssw_pkg::SSW_DELAY);
   wire logic in_run = is_state(state_r, ssw_pkg::SSW_RUN);
   wire logic nxt_delay = is_state(state_nxt, ssw_pkg::SSW_DELAY);
   wire logic nxt_run = is_state(state_nxt, ssw_pkg::SSW_RUN);

   // Supply good means above upper threshold (hysteresis is in the comparator)
   wire logic force_rst = !pins.supply_good || !pins.manual_reset_n;
   wire logic kick_edge = pins.watchdog_kick_in ^ kick_r;
   wire logic dly_done = tick_us && (dly_r >= TD_US - 32'h0000_0001);
   wire logic wd_tout = HAS_WDOG && in_run && !kick_edge
      && tick_us && (wd_r >= TOUT_US - 32'h0000_0001);

   // ****************************************
   // Sequencer
   // ****************************************
   always_comb begin
      state_nxt = state_r;
      case (state_r)
         ssw_pkg::SSW_HOLD: begin
            if (!force_rst) begin
               state_nxt = ssw_pkg::SSW_DELAY;
            end
         end
         ssw_pkg::SSW_DELAY: begin
            if (force_rst) begin
               state_nxt = ssw_pkg::SSW_HOLD;
            end else if (dly_done) begin
               state_nxt = ssw_pkg::SSW_RUN;
            end
         end
         ssw_pkg::SSW_RUN: begin
            if (force_rst) begin
               state_nxt = ssw_pkg::SSW_HOLD;
            end else if (wd_tout) begin
               state_nxt = ssw_pkg::SSW_DELAY;
            end
         end
         default: begin
            state_nxt = ssw_pkg::SSW_HOLD;
         end
      endcase
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         state_r <= ssw_pkg::SSW_HOLD;
         rst_out_r <= 1'b1;
      end else begin
         state_r <= state_nxt;
         rst_out_r <= !nxt_run;
      end
   end

   // Release delay counter, cleared outside the delay state
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         dly_r <= 32'h0000_0000;
      end else if (!in_delay || !nxt_delay) begin
         dly_r <= 32'h0000_0000;
      end else if (tick_us) begin
         dly_r <= dly_r + 32'h0000_0001;
      end
   end

   // ****************************************
   // Watchdog
   // ****************************************
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         kick_r <= 1'b0;
         wd_r <= 32'h0000_0000;
      end else begin
         kick_r <= pins.watchdog_kick_in;
         if (!in_run || kick_edge || wd_tout) begin
            wd_r <= 32'h0000_0000;
         end else if (tick_us) begin
            wd_r <= wd_r + 32'h0000_0001;
         end
      end
   end

   // ****************************************
   // Outputs
   // ****************************************
   assign reset_n = !rst_out_r;
   assign reset_hi = rst_out_r;

   // ****************************************
   // Checks
   // ****************************************
   localparam logic [31:0] TICK_CYC = {16'h0000, `SSW_TICK_CYC};
   localparam logic [31:0] DLY_MIN_CYC = (TD_US - 32'h0000_0001) * TICK_CYC;
   localparam logic [31:0] DLY_MAX_CYC = TD_US * TICK_CYC;
   localparam logic [31:0] TOUT_MIN_CYC = (TOUT_US - 32'h0000_0001) * TICK_CYC;
   localparam logic [31:0] TOUT_MAX_CYC = TOUT_US * TICK_CYC;

   // Clock cycles in the delay state, counted apart from the tick-based counter
   logic [31:0] dly_cyc_r;
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         dly_cyc_r <= 32'h0000_0000;
      end else if (!in_delay || !nxt_delay) begin
         dly_cyc_r <= 32'h0000_0000;
      end else begin
         dly_cyc_r <= dly_cyc_r + 32'h0000_0001;
      end
   end

   // Clock cycles in the run state since the last kick
   logic [31:0] run_cyc_r;
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         run_cyc_r <= 32'h0000_0000;
      end else if (!in_run || kick_edge) begin
         run_cyc_r <= 32'h0000_0000;
      end else begin
         run_cyc_r <= run_cyc_r + 32'h0000_0001;
      end
   end

   a_supply_low_rst: assert property (@(posedge clk_sys) disable iff (!rst_n)
      !pins.supply_good |=> !reset_n) else $error("reset not asserted on low supply");

   a_high_out_on: assert property (@(posedge clk_sys) disable iff (!rst_n)
      !pins.supply_good |=> reset_hi) else $error("high reset not asserted");

   a_manual_rst: assert property (@(posedge clk_sys) disable iff (!rst_n)
      !pins.manual_reset_n |=> !reset_n) else $error("manual reset ignored");

   a_manual_high: assert property (@(posedge clk_sys) disable iff (!rst_n)
      !pins.manual_reset_n |=> reset_hi) else $error("manual reset ignored on high output");

   a_out_compl: assert property (@(posedge clk_sys) disable iff (!rst_n)
      reset_hi == !reset_n) else $error("outputs not complementary");

   a_release_delay: assert property (@(posedge clk_sys) disable iff (!rst_n)
      $rose(reset_n) |-> $past(state_r) == ssw_pkg::SSW_DELAY && $past(dly_done))
      else $error("release without full delay");

   a_delay_len: assert property (@(posedge clk_sys) disable iff (!rst_n)
      $rose(reset_n) |-> $past(dly_cyc_r) >= DLY_MIN_CYC && $past(dly_cyc_r) < DLY_MAX_CYC)
      else $error("release delay length out of range");

   a_delay_start: assert property (@(posedge clk_sys) disable iff (!rst_n)
      in_hold && force_rst |=> in_hold) else $error("delay started with source active");

   a_delay_restart: assert property (@(posedge clk_sys) disable iff (!rst_n)
      in_delay && force_rst |=> in_hold && dly_r == 32'h0000_0000)
      else $error("delay not restarted on fault");

   a_tout_reset: assert property (@(posedge clk_sys) disable iff (!rst_n)
      wd_tout && !force_rst |=> !reset_n && in_delay && wd_r == 32'h0000_0000)
      else $error("timeout without reset");

   a_tout_len: assert property (@(posedge clk_sys) disable iff (!rst_n)
      wd_tout |-> run_cyc_r >= TOUT_MIN_CYC && run_cyc_r < TOUT_MAX_CYC)
      else $error("watchdog interval out of range");

   a_wd_quiet: assert property (@(posedge clk_sys) disable iff (!rst_n)
      !in_run |=> wd_r == 32'h0000_0000) else $error("watchdog ran while reset asserted");

   a_kick_clears: assert property (@(posedge clk_sys) disable iff (!rst_n)
      in_run && kick_edge |=> wd_r == 32'h0000_0000)
      else $error("kick did not restart watchdog");

   a_steady_high: assert property (@(posedge clk_sys) disable iff (!rst_n)
      reset_n |-> $past(pins.manual_reset_n) && $past(pins.supply_good))
      else $error("reset released with source active");
endmodule // ssw_supervisor
`default_nettype wire

// ==== sim/ssw_kicker.sv ====
`timescale 1ns/1ps
`default_nettype none
// ****************
// Processor model
// ****************
module ssw_kicker (
   input wire logic clk_sys,
   input wire logic en,
   output logic kick
);
   logic [9:0] cnt_r = 10'h000;
   initial kick = 1'b0;
   always @(posedge clk_sys) begin
      cnt_r <= cnt_r + 10'h001;
      if (en && cnt_r == 10'h3FF) kick <= !kick;
   end
endmodule // ssw_kicker
`default_nettype wire

// ==== sim/supply_supervisor_watchdog_reset_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin n_fail++; \
$display("Error %0t: mismatch", $time); end end
module supply_supervisor_watchdog_reset_tb;
   logic clk_sys = 1'b0;
   logic rst_n = 1'b0;
   logic sup_r = 1'b0;
   logic man_r = 1'b1;
   logic kick_en = 1'b1;
   logic kick;
   logic reset_n;
   logic reset_hi;
   int n_fail = 0;
   int n_checks = 0;
   int n;
   ssw_pkg::ssw_in_t pins;
   assign pins = {sup_r, man_r, kick};
   always #2.5 clk_sys = !clk_sys;
   ssw_kicker ssw_kicker_i (.clk_sys(clk_sys), .en(kick_en), .kick(kick));
   ssw_supervisor #(.TD_US(32'h5), .TOUT_US(32'h14), .HAS_WDOG(1'b1)) ssw_supervisor_i (
      .clk_sys(clk_sys), .rst_n(rst_n), .pins(pins), .reset_n(reset_n), .reset_hi(reset_hi));
   // ****************
   // Helpers
   // ****************
   task automatic give_verdict();
      $display("checks %0d, mismatches %0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   task automatic wait_rst(input logic v, output int c);
      c = 0;
      while (reset_n !== v && c < 4500) begin
         @(posedge clk_sys);
         #1;
         c++;
      end
      if (c >= 4500) begin
         `CHK(1'b0, 1'b1)
         give_verdict();
      end
   endtask
   task automatic drive(input logic s, input logic m);
      @(posedge clk_sys);
      sup_r <= s;
      man_r <= m;
      @(posedge clk_sys);
      #1;
   endtask
   // ****************
   // Scenarios
   // ****************
   task automatic t_supply();
      repeat (2000) @(posedge clk_sys);
      `CHK(reset_n, 1'b0)
      `CHK(reset_hi, 1'b1)
      drive(1'b1, 1'b1);
      wait_rst(1'b1, n);
      `CHK(n > 790 && n < 1220, 1'b1)
      `CHK(reset_hi, 1'b0)
      drive(1'b0, 1'b1);
      `CHK(reset_n, 1'b0)
      drive(1'b1, 1'b1);
      repeat (500) @(posedge clk_sys);
      drive(1'b0, 1'b1);
      `CHK(reset_n, 1'b0)
      repeat (1500) @(posedge clk_sys);
      `CHK(reset_n, 1'b0)
      drive(1'b1, 1'b1);
      wait_rst(1'b1, n);
      `CHK(n > 790 && n < 1220, 1'b1)
      $display("supply test done");
   endtask
   task automatic t_manual();
      drive(1'b1, 1'b0);
      `CHK(reset_n, 1'b0)
      `CHK(reset_hi, 1'b1)
      drive(1'b1, 1'b1);
      wait_rst(1'b1, n);
      `CHK(n > 790 && n < 1220, 1'b1)
      $display("manual test done");
   endtask
   task automatic t_wdog();
      kick_en <= 1'b0;
      t_manual();
      wait_rst(1'b0, n);
      `CHK(n > 3790 && n < 4220, 1'b1)
      wait_rst(1'b1, n);
      `CHK(n > 790 && n < 1220, 1'b1)
      wait_rst(1'b0, n);
      `CHK(n > 3790 && n < 4220, 1'b1)
      kick_en <= 1'b1;
      wait_rst(1'b1, n);
      `CHK(n > 790 && n < 1220, 1'b1)
      n = 0;
      repeat (6000) begin
         @(posedge clk_sys);
         #1;
         if (reset_n !== 1'b1) n++;
      end
      `CHK(n, 0)
      $display("watchdog test done");
   endtask
   initial begin
      repeat (20) @(posedge clk_sys);
      rst_n <= 1'b1;
      t_supply();
      t_manual();
      t_wdog();
      give_verdict();
   end
endmodule // supply_supervisor_watchdog_reset_tb
`default_nettype wire
